// [common/xdm_pkg.sv]
// package: constants for the external data memory bus block
package xdm_pkg;
  localparam logic [7:0]  SFR_LOW_PORT    = 8'h80;
  localparam logic [7:0]  SFR_HIGH_PORT   = 8'ha0;
  localparam logic [7:0]  SFR_STROBE_PORT = 8'hb0;
  localparam logic [7:0]  SFR_CHIP_CTRL   = 8'h9f;
  localparam int          AUX_EN_BIT      = 4;
  localparam logic [7:0]  PORT_RESET      = 8'hff;
  localparam logic [7:0]  CHIP_CTRL_RESET = 8'h00;
  localparam int          AUX_RAM_BYTES   = 1024;
  localparam logic [15:0] AUX_RAM_TOP     = 16'h03ff;
  localparam int          READ_STROBE_BIT  = 7;
  localparam int          WRITE_STROBE_BIT = 6;
  localparam int          PHASE_CYCLES    = 2;
  typedef enum logic [2:0] {
    XDM_IDLE  = 3'b000,
    XDM_ADDR  = 3'b001,
    XDM_LATCH = 3'b010,
    XDM_STRB  = 3'b011,
    XDM_HOLD  = 3'b100,
    XDM_DONE  = 3'b101
  } xdm_state_t;
endpackage : xdm_pkg

// [src/xdm_bus.sv]
// external data memory bus: multiplexed port sequencer plus on-chip aux ram
// Functional notes
// - two forms: 16-bit address from data pointer, 8-bit from indirect index register
// - aux ram enable set sends 000h..3ffh to on-chip ram, cleared goes external
// - 16-bit: low addr/data on low port, high addr on high port, strobes on pins
// - during 16-bit access these pins belong to the bus, not general I/O
// - 8-bit: high address port stays under software control for paging
// - low address and data byte share the low port, one after the other
// - latch strobe pulses; low address valid at its falling edge
// - write data driven on the same edge as the write strobe falls and held until after release
// - read data sampled just before the read strobe is released
// - any external access loads 0ffh into the low port output latch
// - 16-bit form reaches up to 64k bytes of external space
// - 1024-byte aux ram at 000h..3ffh, reached only by external-move accesses
module xdm_bus #(
  parameter int AUX_BYTES = xdm_pkg::AUX_RAM_BYTES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic        req_wide,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  output logic             resp_valid,
  output logic [7:0]       resp_rdata,
  output logic             busy,
  input  wire logic        sfr_we,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  input  wire logic [7:0]  low_port_in,
  output logic [7:0]       low_port_out,
  output logic [7:0]       low_port_oe,
  output logic [7:0]       high_port_out,
  output logic             latch_strobe,
  output logic [7:0]       strobe_port_out
);
  import xdm_pkg::*;

  xdm_state_t  state_q;
  logic [7:0]  low_latch_q, high_latch_q, strobe_latch_q, chip_ctrl_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic        write_q, wide_q;
  logic [1:0]  phase_q;
  logic [7:0]  aux_ram [AUX_BYTES];
  logic        aux_hit;
  logic        ext_go;
  logic        phase_end;
  logic [15:0] req_eff;

  // the 8-bit form only carries a low byte; treat its upper byte as zero
  function automatic logic [15:0] eff_addr(input logic wide, input logic [15:0] a);
    eff_addr = wide ? a : {8'h00, a[7:0]};
  endfunction : eff_addr

  // the 8-bit form must index aux ram by its low byte only, whatever sits above it
  assign req_eff   = eff_addr(req_wide, req_addr);
  assign aux_hit   = chip_ctrl_q[AUX_EN_BIT] &&
                     (req_eff <= AUX_RAM_TOP);
  assign ext_go    = req && !busy && !aux_hit;
  assign phase_end = (phase_q == 2'(PHASE_CYCLES - 1));

  // sequencer: address phase, latch fall, strobe, hold, release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= XDM_IDLE;
      phase_q <= 2'd0;
    end else begin
      unique case (state_q)
        XDM_IDLE: begin
          phase_q <= 2'd0;
          if (ext_go) state_q <= XDM_ADDR;
        end
        XDM_ADDR: begin
          phase_q <= phase_q + 2'd1;
          if (phase_end) begin
            phase_q <= 2'd0;
            state_q <= XDM_LATCH;
          end
        end
        XDM_LATCH: state_q <= XDM_STRB;
        XDM_STRB: begin
          phase_q <= phase_q + 2'd1;
          if (phase_end) begin
            phase_q <= 2'd0;
            state_q <= XDM_HOLD;
          end
        end
        XDM_HOLD: state_q <= XDM_DONE;
        XDM_DONE: state_q <= XDM_IDLE;
        default:  state_q <= XDM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      write_q <= 1'b0;
      wide_q  <= 1'b0;
    end else if (ext_go) begin
      addr_q  <= eff_addr(req_wide, req_addr);
      wdata_q <= req_wdata;
      write_q <= req_write;
      wide_q  <= req_wide;
    end
  end

  // software latches; bus access overrides the low port latch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_latch_q    <= PORT_RESET;
      high_latch_q   <= PORT_RESET;
      strobe_latch_q <= PORT_RESET;
      chip_ctrl_q    <= CHIP_CTRL_RESET;
    end else begin
      if (sfr_we && sfr_addr == SFR_LOW_PORT)    low_latch_q    <= sfr_wdata;
      if (sfr_we && sfr_addr == SFR_HIGH_PORT)   high_latch_q   <= sfr_wdata;
      if (sfr_we && sfr_addr == SFR_STROBE_PORT) strobe_latch_q <= sfr_wdata;
      if (sfr_we && sfr_addr == SFR_CHIP_CTRL)   chip_ctrl_q    <= sfr_wdata;
      // hardware wins over a same-cycle software write
      if (ext_go) low_latch_q <= PORT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
    end else begin
      unique case (sfr_addr)
        SFR_LOW_PORT:    sfr_rdata <= low_latch_q;
        SFR_HIGH_PORT:   sfr_rdata <= high_latch_q;
        SFR_STROBE_PORT: sfr_rdata <= strobe_latch_q;
        SFR_CHIP_CTRL:   sfr_rdata <= chip_ctrl_q;
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

  // on-chip aux ram, one-cycle access; never visible on the pins
  always_ff @(posedge clk) begin
    if (req && !busy && aux_hit && req_write)
      aux_ram[req_eff[9:0]] <= req_wdata;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      resp_valid <= 1'b0;
      resp_rdata <= 8'h00;
      busy       <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      if (req && !busy && aux_hit) begin
        resp_valid <= 1'b1;
        if (!req_write) resp_rdata <= aux_ram[req_eff[9:0]];
      end
      if (ext_go) busy <= 1'b1;
      if (state_q == XDM_HOLD && !write_q) resp_rdata <= low_port_in;
      if (state_q == XDM_DONE) begin
        resp_valid <= 1'b1;
        busy       <= 1'b0;
      end
    end
  end

  // pin drive, all registered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_port_out    <= PORT_RESET;
      low_port_oe     <= 8'h00;
      high_port_out   <= PORT_RESET;
      latch_strobe    <= 1'b0;
      strobe_port_out <= PORT_RESET;
    end else begin
      low_port_out    <= low_latch_q;
      low_port_oe     <= 8'h00;
      high_port_out   <= high_latch_q;
      latch_strobe    <= 1'b0;
      strobe_port_out <= strobe_latch_q;
      unique case (state_q)
        XDM_IDLE: ;
        XDM_ADDR: begin
          low_port_out <= addr_q[7:0];
          low_port_oe  <= 8'hff;
          latch_strobe <= 1'b1;
          strobe_port_out[READ_STROBE_BIT]  <= 1'b1;
          strobe_port_out[WRITE_STROBE_BIT] <= 1'b1;
        end
        XDM_LATCH: begin
          // latch strobe falls with the address still driven
          low_port_out <= addr_q[7:0];
          low_port_oe  <= 8'hff;
          strobe_port_out[READ_STROBE_BIT]  <= 1'b1;
          strobe_port_out[WRITE_STROBE_BIT] <= 1'b1;
        end
        XDM_STRB, XDM_HOLD: begin
          low_port_out <= wdata_q;
          low_port_oe  <= write_q ? 8'hff : 8'h00;
          strobe_port_out[READ_STROBE_BIT]  <= write_q;
          strobe_port_out[WRITE_STROBE_BIT] <= !write_q;
        end
        XDM_DONE: begin
          // strobe released, write data still held one more cycle
          low_port_out <= wdata_q;
          low_port_oe  <= write_q ? 8'hff : 8'h00;
          strobe_port_out[READ_STROBE_BIT]  <= 1'b1;
          strobe_port_out[WRITE_STROBE_BIT] <= 1'b1;
        end
        default: ;
      endcase
      if (state_q != XDM_IDLE && wide_q) high_port_out <= addr_q[15:8];
    end
  end

  strobes_apart_a: assert property (@(posedge clk) disable iff (!nrst)
    !(!strobe_port_out[READ_STROBE_BIT] && !strobe_port_out[WRITE_STROBE_BIT]))
    else $error("read and write strobes both low");

  latch_before_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(strobe_port_out[READ_STROBE_BIT] & strobe_port_out[WRITE_STROBE_BIT]) && busy
    |-> $past(latch_strobe, 2) && !latch_strobe)
    else $error("data strobe without preceding latch pulse");

  addr_at_latch_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(latch_strobe) |-> low_port_oe == 8'hff && low_port_out == addr_q[7:0])
    else $error("low address not valid at latch fall");

  write_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(strobe_port_out[WRITE_STROBE_BIT]) && $past(state_q) == XDM_DONE
    |-> low_port_oe == 8'hff && low_port_out == wdata_q)
    else $error("write data not held past strobe");

  high_addr_a: assert property (@(posedge clk) disable iff (!nrst)
    !latch_strobe ##1 latch_strobe && wide_q |-> high_port_out == addr_q[15:8])
    else $error("high address not driven in wide access");

  paging_free_a: assert property (@(posedge clk) disable iff (!nrst)
    busy && !wide_q && $stable(high_latch_q) |=> high_port_out == $past(high_latch_q))
    else $error("high port taken in 8-bit access");

  latch_ff_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_go |=> low_latch_q == PORT_RESET)
    else $error("low port latch not set to ff");

  aux_local_a: assert property (@(posedge clk) disable iff (!nrst)
    req && !busy && aux_hit |=> resp_valid ##1 !latch_strobe && !busy)
    else $error("aux ram access reached the pins");

  ext_done_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_go |-> ##8 resp_valid)
    else $error("external access did not finish in 8 cycles");

  read_sample_a: assert property (@(posedge clk) disable iff (!nrst)
    state_q == XDM_HOLD && !write_q |=> resp_rdata == $past(low_port_in))
    else $error("read data not sampled before strobe release");

  busy_span_a: assert property (@(posedge clk) disable iff (!nrst)
    ext_go |=> busy [*7] ##1 !busy)
    else $error("busy not held for the whole external access");

  idle_release_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(state_q) == XDM_IDLE |-> low_port_oe == 8'h00 && !latch_strobe)
    else $error("bus pins driven outside an access");

  read_float_a: assert property (@(posedge clk) disable iff (!nrst)
    !strobe_port_out[READ_STROBE_BIT] |-> low_port_oe == 8'h00)
    else $error("low port driven while read strobe low");

  write_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    !strobe_port_out[WRITE_STROBE_BIT] && $past(state_q) != XDM_IDLE
    |-> low_port_oe == 8'hff && low_port_out == wdata_q)
    else $error("write data not driven while write strobe low");

  strobe_high_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(state_q) inside {XDM_ADDR, XDM_LATCH, XDM_DONE}
    |-> strobe_port_out[READ_STROBE_BIT] && strobe_port_out[WRITE_STROBE_BIT])
    else $error("data strobe low outside the strobe phase");

  low_addr_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(state_q) inside {XDM_ADDR, XDM_LATCH}
    |-> low_port_oe == 8'hff && low_port_out == addr_q[7:0])
    else $error("low address not driven in address phase");

  latch_width_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(latch_strobe) |=> latch_strobe ##1 !latch_strobe)
    else $error("latch strobe pulse has wrong width");

  aux_off_a: assert property (@(posedge clk) disable iff (!nrst)
    req && !busy && !chip_ctrl_q[AUX_EN_BIT] |=> busy)
    else $error("access with aux ram off did not go external");

  aux_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    req && !busy && aux_hit |=> state_q == XDM_IDLE && low_port_oe == 8'h00)
    else $error("aux ram access started the pin sequencer");

  high_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    wide_q && $past(state_q) != XDM_IDLE |-> high_port_out == addr_q[15:8])
    else $error("high port not held by the bus in wide access");

  sfr_high_a: assert property (@(posedge clk) disable iff (!nrst)
    sfr_we && sfr_addr == SFR_HIGH_PORT |=> high_latch_q == $past(sfr_wdata))
    else $error("software write to high port latch lost");
endmodule : xdm_bus

// [verification/tb_top.sv]
// self-checking bench for the external data memory bus
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import xdm_pkg::*;
  logic clk = 0, nrst = 0, req = 0, req_write = 0, req_wide = 0, sfr_we = 0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0]  req_wdata = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, rd;
  logic        resp_valid, busy, latch_strobe;
  logic [7:0]  resp_rdata, sfr_rdata, low_port_in, low_port_out, low_port_oe;
  logic [7:0]  high_port_out, strobe_port_out;
  int          n_mismatch = 0, samples_checked = 0;
  always #5 clk = ~clk;
  xdm_bus dut (.clk(clk), .nrst(nrst), .req(req), .req_write(req_write), .req_wide(req_wide),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .busy(busy), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .low_port_in(low_port_in),
    .low_port_out(low_port_out), .low_port_oe(low_port_oe), .high_port_out(high_port_out),
    .latch_strobe(latch_strobe), .strobe_port_out(strobe_port_out));
  xdm_mem_model u_mem (.clk(clk), .low_port_out(low_port_out), .low_port_oe(low_port_oe),
    .high_port_out(high_port_out), .latch_strobe(latch_strobe),
    .strobe_port_out(strobe_port_out), .pins(low_port_in));
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    sfr_we = 1; sfr_addr = a; sfr_wdata = d;
    @(posedge clk); #1;
    sfr_we = 0;
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk); #1;
    sfr_addr = a;
    @(posedge clk); #1;
    chk(sfr_rdata, exp);
  endtask : sfr_rd
  // one access; ext says whether the pins must move, hi is the expected high port
  task automatic acc(input logic w, input logic wd, input logic [15:0] a,
                     input logic [7:0] d, input logic ext, input logic [7:0] hi);
    int n;
    logic saw, prev;
    @(posedge clk); #1;
    req = 1; req_write = w; req_wide = wd; req_addr = a; req_wdata = d;
    @(posedge clk); #1;
    req = 0; saw = 0; n = 0;
    chk(busy, ext);
    while (resp_valid !== 1'b1) begin
      if (n == 20) begin
        n_mismatch++;
        print_verdict();
      end
      prev = latch_strobe;
      @(posedge clk); #1;
      n++;
      if (prev === 1'b1 && latch_strobe === 1'b0) begin
        saw = 1;
        chk(low_port_out, a[7:0]);
      end
      chk(strobe_port_out[7] | strobe_port_out[6], 1'b1);
      if (strobe_port_out[7:6] !== 2'b11) chk(high_port_out, hi);
      if (strobe_port_out[6] === 1'b0) chk({low_port_oe, low_port_out}, {8'hff, d});
      if (strobe_port_out[7] === 1'b0) chk(low_port_oe, 8'h00);
    end
    chk(saw, ext);
    rd = resp_rdata;
  endtask : acc
  task automatic test_reset();
    chk({low_port_oe, strobe_port_out}, 16'h00ff);
    sfr_rd(SFR_LOW_PORT, 8'hff);
    sfr_rd(SFR_HIGH_PORT, 8'hff);
    sfr_rd(SFR_STROBE_PORT, 8'hff);
    sfr_rd(SFR_CHIP_CTRL, CHIP_CTRL_RESET);
    sfr_rd(8'h81, 8'h00);
    $display("test reset done");
  endtask : test_reset
  task automatic test_wide();
    acc(1, 1, 16'h1234, 8'h5a, 1, 8'h12);
    chk(u_mem.mem[16'h1234], 8'h5a);
    acc(1, 1, 16'hffff, 8'hc3, 1, 8'hff);
    acc(0, 1, 16'h1234, 8'h00, 1, 8'h12);
    chk(rd, 8'h5a);
    acc(0, 1, 16'hffff, 8'h00, 1, 8'hff);
    chk(rd, 8'hc3);
    $display("test wide done");
  endtask : test_wide
  task automatic test_low_latch();
    sfr_wr(SFR_LOW_PORT, 8'h3c);
    sfr_rd(SFR_LOW_PORT, 8'h3c);
    acc(0, 1, 16'h1234, 8'h00, 1, 8'h12);
    sfr_rd(SFR_LOW_PORT, 8'hff);
    $display("test low latch done");
  endtask : test_low_latch
  task automatic test_paging();
    sfr_wr(SFR_HIGH_PORT, 8'h02);
    acc(1, 0, 16'hff40, 8'h77, 1, 8'h02);
    chk(u_mem.mem[16'h0240], 8'h77);
    acc(0, 0, 16'h0040, 8'h00, 1, 8'h02);
    chk(rd, 8'h77);
    sfr_rd(SFR_HIGH_PORT, 8'h02);
    $display("test paging done");
  endtask : test_paging
  task automatic test_aux();
    sfr_wr(SFR_HIGH_PORT, 8'hff);
    acc(1, 1, 16'h0010, 8'h11, 1, 8'h00);
    sfr_wr(SFR_CHIP_CTRL, 8'h10);
    acc(1, 1, 16'h0010, 8'ha5, 0, 8'h00);
    acc(1, 1, 16'h03ff, 8'h66, 0, 8'h03);
    acc(1, 1, 16'h0400, 8'h99, 1, 8'h04);
    chk(u_mem.mem[16'h0010], 8'h11);
    acc(0, 1, 16'h0010, 8'h00, 0, 8'h00);
    chk(rd, 8'ha5);
    acc(0, 1, 16'h03ff, 8'h00, 0, 8'h03);
    chk(rd, 8'h66);
    acc(1, 0, 16'hff20, 8'h4b, 0, 8'h00);
    acc(0, 1, 16'h0020, 8'h00, 0, 8'h00);
    chk(rd, 8'h4b);
    acc(0, 0, 16'h0120, 8'h00, 0, 8'h00);
    chk(rd, 8'h4b);
    sfr_wr(SFR_CHIP_CTRL, 8'h00);
    acc(0, 1, 16'h0010, 8'h00, 1, 8'h00);
    chk(rd, 8'h11);
    $display("test aux done");
  endtask : test_aux
  // a request held into the busy cycle must be ignored, not queued
  task automatic test_refused();
    int n;
    @(posedge clk); #1;
    req = 1; req_write = 1; req_wide = 1; req_addr = 16'h2001; req_wdata = 8'h3e;
    @(posedge clk); #1;
    req_addr = 16'h2002; req_wdata = 8'he3;
    @(posedge clk); #1;
    req = 0; n = 0;
    chk(busy, 1'b1);
    while (resp_valid !== 1'b1) begin
      if (n == 20) begin
        n_mismatch++;
        print_verdict();
      end
      @(posedge clk); #1;
      n++;
    end
    repeat (12) @(posedge clk);
    #1;
    chk({busy, resp_valid}, 2'b00);
    chk(u_mem.mem[16'h2001], 8'h3e);
    chk(u_mem.mem[16'h2002] === 8'he3, 1'b0);
    $display("test refused done");
  endtask : test_refused
  initial begin
    repeat (16) @(posedge clk);
    #1;
    nrst = 1;
    test_reset();
    test_wide();
    test_low_latch();
    test_paging();
    test_aux();
    test_refused();
    print_verdict();
  end
endmodule : tb_top

// [verification/xdm_mem_model.sv]
// external address latch plus asynchronous static ram on the multiplexed bus
module xdm_mem_model (
  input  wire logic       clk,
  input  wire logic [7:0] low_port_out,
  input  wire logic [7:0] low_port_oe,
  input  wire logic [7:0] high_port_out,
  input  wire logic       latch_strobe,
  input  wire logic [7:0] strobe_port_out,
  output logic [7:0]      pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  logic [7:0] addr_lo_q;
  logic [7:0] idle_q = 8'h55;
  logic [7:0] ram_q;
  always @(negedge latch_strobe) addr_lo_q = low_port_out;
  // the ram commits on the rising write strobe, so late data removal shows up
  always @(posedge strobe_port_out[6]) begin
    if (low_port_oe === 8'hff) mem[{high_port_out, addr_lo_q}] = low_port_out;
  end
  // undriven lines toggle every cycle so a stale value is never mistaken for data
  always @(posedge clk) idle_q <= ~idle_q;
  assign ram_q = strobe_port_out[7] ? idle_q : mem[{high_port_out, addr_lo_q}];
  assign pins  = (low_port_oe & low_port_out) | (~low_port_oe & ram_q);
endmodule : xdm_mem_model
